//--- src/sraln_pkg.sv
// Package: register map, field layout and reset values of the align block
package sraln_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DLY_W  = 8;
  localparam int unsigned POS_W  = 24;
  localparam int unsigned SEL_W  = 4;

  localparam logic [ADDR_W-1:0] ADDR_ALIGN_EN   = 12'h028;
  localparam logic [ADDR_W-1:0] ADDR_ALIGN_CFG  = 12'h029;
  localparam logic [ADDR_W-1:0] ADDR_ALIGN_STAT = 12'h02a;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_CRS = 12'h02b;
  localparam logic [ADDR_W-1:0] ADDR_POS_LOW    = 12'h02c;
  localparam logic [ADDR_W-1:0] ADDR_POS_MID    = 12'h02d;
  localparam logic [ADDR_W-1:0] ADDR_POS_HIGH   = 12'h02e;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_INV = 12'h02f;
  localparam logic [ADDR_W-1:0] ADDR_DLY_INV    = 12'h030;
  localparam logic [ADDR_W-1:0] ADDR_DLY_COARSE = 12'h031;
  localparam logic [ADDR_W-1:0] ADDR_DLY_FINE   = 12'h032;
  localparam logic [ADDR_W-1:0] ADDR_POS_SELECT = 12'h033;

  localparam int unsigned EN_BIT     = 0;
  localparam int unsigned INV_BIT    = 0;
  localparam int unsigned DONE_BIT   = 0;
  localparam int unsigned BUSY_BIT   = 1;
  localparam int unsigned PVALID_BIT = 2;

  localparam logic [DATA_W-1:0] CFG_RST    = 8'h0f;
  localparam logic [DLY_W-1:0]  COARSE_RST = 8'h00;
  localparam logic [DLY_W-1:0]  FINE_RST   = 8'h00;
  localparam logic [SEL_W-1:0]  SEL_RST    = 4'h0;
  localparam logic [POS_W-1:0]  POS_RST    = 24'hffffff;

  localparam logic [1:0] EDGES_FOR_VALID = 2'h3;

  typedef enum logic [0:0] {
    SRALN_IDLE,
    SRALN_SEARCH
  } sraln_state_t;
endpackage : sraln_pkg

//--- src/sraln_posdet.sv
// Module: SYSREF position status capture
`timescale 1ns/1ps
module sraln_posdet
  import sraln_pkg::*;
#(
  parameter int unsigned WIDTH = POS_W
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             sysref_i,
  input  wire logic [WIDTH-1:0] pos_raw_i,
  output logic      [WIDTH-1:0] pos_status_o,
  output logic                  pos_valid_o
);
  logic       sysref_q;
  logic [1:0] edge_cnt_q;
  logic       rise;

  assign rise = sysref_i && !sysref_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref_i;
    end
  end

  // Count edges until the detector has seen enough
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      edge_cnt_q <= 2'h0;
    end else if (rise && edge_cnt_q != EDGES_FOR_VALID) begin
      edge_cnt_q <= edge_cnt_q + 2'h1;
    end
  end

  assign pos_valid_o = (edge_cnt_q == EDGES_FOR_VALID);

  // Latch risky positions; end positions always flagged
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_status_o <= POS_RST;
    end else if (rise && pos_valid_o) begin
      pos_status_o <= pos_raw_i | {1'b1, {(WIDTH-2){1'b0}}, 1'b1};
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_pos_latch: assert property (rise && pos_valid_o |=>
    pos_status_o == ($past(pos_raw_i) | {1'b1, {(WIDTH-2){1'b0}}, 1'b1}))
    else $error("position status not latched from detector");
  c_pos_valid: cover property (rise && pos_valid_o);
endmodule : sraln_posdet

//--- src/sraln_top.sv
// Module: automatic SYSREF alignment search and its registers
`timescale 1ns/1ps
// Contract
// - On enable the block steps the delay until the clock edge meets SYSREF.
// - A done flag in the status register is set when the search completes; a disable leaves it clear.
// - The found delay setting is readable in a result field after completion.
// - The found setting stays applied until software changes it.
// - Software may disable the search and write fine at any time; inversion and coarse writes apply only while idle.
// - Both polarities are tried and the smaller coarse delay is chosen.
// - A position status bit reads 1 when risky and 0 when safe.
module sraln_top
  import sraln_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              sysref_i,
  input  wire logic              phase_late_i,
  input  wire logic [POS_W-1:0]  pos_raw_i,
  output logic                   clock_polarity_invert_o,
  output logic      [DLY_W-1:0]  coarse_aperture_delay_o,
  output logic      [DLY_W-1:0]  fine_aperture_delay_o,
  output logic      [SEL_W-1:0]  sampling_position_select_o
);
  localparam logic [DLY_W-1:0] COARSE_MAX = 8'hff;

  sraln_state_t      state_q;
  logic              auto_align_enable_q;
  logic [DATA_W-1:0] auto_align_config_q;
  logic              align_done_flag_q;
  logic              inv_q;
  logic [DLY_W-1:0]  coarse_q;
  logic [DLY_W-1:0]  fine_q;
  logic [SEL_W-1:0]  sel_q;
  logic              res_inv_q;
  logic [DLY_W-1:0]  res_coarse_q;
  logic [DLY_W:0]    best0_q;
  logic [DATA_W-1:0] wait_q;
  logic [POS_W-1:0]  pos_status;
  logic              pos_valid;
  logic              idle;
  logic              start;
  logic              step_end;
  logic              hit_end;
  logic              fin;
  logic [DLY_W:0]    cand;
  logic              pick_inv;

  sraln_posdet #(
    .WIDTH (POS_W)
  ) u_posdet (
    .ref_clk_i    (ref_clk_i),
    .rst_b_i      (rst_b_i),
    .sysref_i     (sysref_i),
    .pos_raw_i    (pos_raw_i),
    .pos_status_o (pos_status),
    .pos_valid_o  (pos_valid)
  );

  assign idle  = (state_q == SRALN_IDLE);
  assign start = idle && reg_wr_i && (reg_addr_i == ADDR_ALIGN_EN)
                 && reg_wdata_i[EN_BIT];
  // One trial ends when the settle wait has run out
  assign step_end = !idle && auto_align_enable_q && (wait_q == 8'h00);
  assign hit_end  = step_end && (phase_late_i || coarse_q == COARSE_MAX);
  assign fin      = hit_end && inv_q;
  // Missed edge ranks above any real hit
  assign cand     = {!phase_late_i, coarse_q};
  assign pick_inv = (cand < best0_q);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      auto_align_enable_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ADDR_ALIGN_EN) begin
      auto_align_enable_q <= reg_wdata_i[EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      auto_align_config_q <= CFG_RST;
    end else if (reg_wr_i && reg_addr_i == ADDR_ALIGN_CFG) begin
      auto_align_config_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fine_q <= FINE_RST;
      sel_q  <= SEL_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_DLY_FINE) begin
        fine_q <= reg_wdata_i;
      end
      if (reg_addr_i == ADDR_POS_SELECT) begin
        sel_q <= reg_wdata_i[SEL_W-1:0];
      end
    end
  end

  // Search sequencer
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= SRALN_IDLE;
      wait_q  <= 8'h00;
      best0_q <= '0;
    end else begin
      case (state_q)
        SRALN_IDLE: begin
          if (start) begin
            state_q <= SRALN_SEARCH;
            wait_q  <= auto_align_config_q;
          end
        end
        SRALN_SEARCH: begin
          if (!auto_align_enable_q || fin) begin
            state_q <= SRALN_IDLE;
          end else if (hit_end) begin
            best0_q <= cand;
            wait_q  <= auto_align_config_q;
          end else if (step_end) begin
            wait_q <= auto_align_config_q;
          end else begin
            wait_q <= wait_q - 8'h01;
          end
        end
        default: begin
          state_q <= SRALN_IDLE;
        end
      endcase
    end
  end

  // Delay setting: trial value while searching, else kept or written
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inv_q    <= 1'b0;
      coarse_q <= COARSE_RST;
    end else if (start) begin
      inv_q    <= 1'b0;
      coarse_q <= COARSE_RST;
    end else if (fin) begin
      inv_q    <= pick_inv;
      coarse_q <= pick_inv ? coarse_q : best0_q[DLY_W-1:0];
    end else if (hit_end) begin
      inv_q    <= 1'b1;
      coarse_q <= COARSE_RST;
    end else if (step_end) begin
      coarse_q <= coarse_q + 8'h01;
    end else if (idle && reg_wr_i) begin
      if (reg_addr_i == ADDR_DLY_INV) begin
        inv_q <= reg_wdata_i[INV_BIT];
      end
      if (reg_addr_i == ADDR_DLY_COARSE) begin
        coarse_q <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_inv_q    <= 1'b0;
      res_coarse_q <= COARSE_RST;
    end else if (fin) begin
      res_inv_q    <= pick_inv;
      res_coarse_q <= pick_inv ? coarse_q : best0_q[DLY_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      align_done_flag_q <= 1'b0;
    end else if (start) begin
      align_done_flag_q <= 1'b0;
    end else if (fin) begin
      align_done_flag_q <= 1'b1;
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_ALIGN_EN:   reg_rdata_o <= {7'h00, auto_align_enable_q};
        ADDR_ALIGN_CFG:  reg_rdata_o <= auto_align_config_q;
        ADDR_ALIGN_STAT: reg_rdata_o <= {5'h00, pos_valid, !idle,
                                         align_done_flag_q};
        ADDR_RESULT_CRS: reg_rdata_o <= res_coarse_q;
        ADDR_RESULT_INV: reg_rdata_o <= {7'h00, res_inv_q};
        ADDR_POS_LOW:    reg_rdata_o <= pos_status[7:0];
        ADDR_POS_MID:    reg_rdata_o <= pos_status[15:8];
        ADDR_POS_HIGH:   reg_rdata_o <= pos_status[23:16];
        ADDR_DLY_INV:    reg_rdata_o <= {7'h00, inv_q};
        ADDR_DLY_COARSE: reg_rdata_o <= coarse_q;
        ADDR_DLY_FINE:   reg_rdata_o <= fine_q;
        ADDR_POS_SELECT: reg_rdata_o <= {4'h0, sel_q};
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign clock_polarity_invert_o    = inv_q;
  assign coarse_aperture_delay_o    = coarse_q;
  assign fine_aperture_delay_o      = fine_q;
  assign sampling_position_select_o = sel_q;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_done_clr_start: assert property (start |=> !align_done_flag_q)
    else $error("done flag not cleared on start");
  a_done_low_busy: assert property (!idle |-> !align_done_flag_q)
    else $error("done flag high during search");
  a_fin_sets_done: assert property (fin |=> align_done_flag_q && idle)
    else $error("done flag not set at end of search");
  a_result_used: assert property (fin |=>
    coarse_q == res_coarse_q && inv_q == res_inv_q)
    else $error("result field differs from applied delay");
  a_keep_delay: assert property (idle && !reg_wr_i |=>
    $stable(coarse_q) && $stable(inv_q))
    else $error("calibrated delay changed without a write");
  a_manual_coarse: assert property (idle && !start && reg_wr_i &&
    reg_addr_i == ADDR_DLY_COARSE |=> coarse_q == $past(reg_wdata_i))
    else $error("manual coarse write not applied");
  a_search_step: assert property (step_end && !hit_end |=>
    coarse_q == $past(coarse_q) + 8'h01 &&
    wait_q == $past(auto_align_config_q))
    else $error("search did not step the coarse delay");
  a_start_normal: assert property (start |=>
    !inv_q && coarse_q == COARSE_RST)
    else $error("search did not open with normal polarity");
  a_pol_order: assert property (hit_end && !inv_q |=>
    inv_q && coarse_q == COARSE_RST && !idle)
    else $error("polarity not swept in order");
  a_pick_small: assert property (fin |=>
    (res_inv_q == ($past(cand) < $past(best0_q))))
    else $error("did not choose the smaller coarse delay");

  c_start: cover property (start);
  c_pick_inv: cover property (fin && pick_inv);
  c_pick_norm: cover property (fin && !pick_inv);
  c_abort: cover property (!idle && !auto_align_enable_q);
endmodule : sraln_top

//--- tb/sraln_partner.sv
// Partner model: SYSREF source and phase comparator for the search
`timescale 1ns/1ps
module sraln_partner #(
  parameter int unsigned PERIOD = 16
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       polarity_i,
  input  wire logic [7:0] coarse_i,
  input  wire logic [8:0] thr0_i,
  input  wire logic [8:0] thr1_i,
  output logic            sysref_o,
  output logic            phase_late_o
);
  int unsigned cnt_q;
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q    <= 0;
      sysref_o <= 1'b0;
    end else begin
      cnt_q    <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      sysref_o <= (cnt_q < PERIOD / 2);
    end
  end
  // Late once the trial delay reaches the edge of this polarity
  assign phase_late_o = {1'b0, coarse_i} >= (polarity_i ? thr1_i : thr0_i);
endmodule : sraln_partner

//--- tb/test_sysref_auto_calibration.sv
// Testbench: self-checking bench of the align block
`timescale 1ns/1ps
module test_sysref_auto_calibration;
  import sraln_pkg::*;
  logic              ref_clk_i, rst_b_i, reg_wr_i, reg_rd_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, d;
  logic              sysref, late, inv;
  logic [POS_W-1:0]  pos_raw_i;
  logic [DLY_W-1:0]  crs, fine, f;
  logic [SEL_W-1:0]  sel;
  logic [8:0]        thr0, thr1;
  int                miscompares, comparisons, n, t0, t1, k0, k1;
  int                tt0[6] = '{0, 0, 12, 300, 9, 40};
  int                tt1[6] = '{0, 0, 12, 30, 300, 39};

  sraln_top sraln_top_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .sysref_i(sysref), .phase_late_i(late), .pos_raw_i(pos_raw_i),
    .clock_polarity_invert_o(inv), .coarse_aperture_delay_o(crs),
    .fine_aperture_delay_o(fine), .sampling_position_select_o(sel));
  sraln_partner sraln_partner_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .polarity_i(inv), .coarse_i(crs), .thr0_i(thr0), .thr1_i(thr1),
    .sysref_o(sysref), .phase_late_o(late));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic results;
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 v = reg_rdata_o;
  endtask : rd

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(77988));
    {rst_b_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    pos_raw_i = POS_W'($urandom);
    thr0 = 9'h000;
    thr1 = 9'h000;
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_POS_LOW + ADDR_W'(i), d);
      check(24'(d), 24'hff);
    end
    rd(ADDR_ALIGN_CFG, d);
    check(24'(d), 24'(CFG_RST));
    check({inv, crs, fine, sel}, 24'h0);
    for (int i = 0; i < 6; i++) begin
      t0 = (i < 2) ? $urandom_range(3, 60) : tt0[i];
      t1 = (i < 2) ? $urandom_range(3, 60) : tt1[i];
      @(posedge ref_clk_i);
      thr0 <= 9'(t0);
      thr1 <= 9'(t1);
      wr(ADDR_POS_SELECT, 8'h00);
      wr(ADDR_ALIGN_CFG, 8'($urandom_range(0, 3)));
      wr(ADDR_ALIGN_EN, 8'h01);
      rd(ADDR_ALIGN_STAT, d);
      check(24'(d[1:0]), 24'h2);
      n = 0;
      do begin
        rd(ADDR_ALIGN_STAT, d);
        n++;
      end while (d[DONE_BIT] !== 1'b1 && n < 1000);
      check(24'(d[1:0]), 24'h1);
      k0 = (t0 > 255) ? 511 : t0;
      k1 = (t1 > 255) ? 511 : t1;
      rd(ADDR_RESULT_CRS, d);
      check(24'(d), 24'((k1 < k0 ? k1 : k0) % 256));
      rd(ADDR_RESULT_INV, d);
      check(24'(d[0]), 24'(k1 < k0));
      check({inv, crs}, {k1 < k0, 8'((k1 < k0 ? k1 : k0) % 256)});
    end
    @(posedge ref_clk_i);
    thr0 <= 9'd300;
    wr(ADDR_ALIGN_EN, 8'h01);
    repeat (20) @(posedge ref_clk_i);
    wr(ADDR_DLY_INV, 8'h01);
    @(posedge ref_clk_i);
    #1 check(24'(inv), 24'h0);
    wr(ADDR_ALIGN_EN, 8'h00);
    rd(ADDR_ALIGN_STAT, d);
    check(24'(d[1:0]), 24'h0);
    f = 8'($urandom);
    wr(ADDR_DLY_INV, 8'h01);
    wr(ADDR_DLY_COARSE, 8'h5a);
    wr(ADDR_DLY_FINE, f);
    repeat (2) @(posedge ref_clk_i);
    check({inv, crs, fine}, {1'b1, 8'h5a, f});
    rd(ADDR_DLY_COARSE, d);
    check(24'(d), 24'h5a);
    rd(ADDR_ALIGN_EN, d);
    check(24'(d), 24'h0);
    wr(ADDR_POS_SELECT, f);
    rd(ADDR_POS_SELECT, d);
    check(24'(d), 24'({4'h0, f[3:0]}));
    check(24'(sel), 24'(f[3:0]));
    wr(12'h100, 8'h55);
    rd(12'h100, d);
    check(24'(d), 24'h0);
    wr(ADDR_POS_LOW, 8'h00);
    rd(ADDR_ALIGN_STAT, d);
    check(24'(d[PVALID_BIT]), 24'h1);
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_POS_LOW + ADDR_W'(i), d);
      check(24'(d), 24'(((pos_raw_i | 24'h800001) >> (8 * i)) & 8'hff));
    end
    results();
  end
endmodule : test_sysref_auto_calibration
